// >>> src/epb_defs.svh
// Register offsets, field positions, reset values and sizes of the buffer
`ifndef EPB_DEFS_SVH
`define EPB_DEFS_SVH
// Memory geometry
`define EPB_AW 13
`define EPB_MEM_BYTES 8192
// Register byte offsets
`define EPB_OFS_CTRL 8'h00
`define EPB_OFS_STAT 8'h04
`define EPB_OFS_RXST 8'h08
`define EPB_OFS_RXND 8'h0C
`define EPB_OFS_RXWR 8'h10
`define EPB_OFS_RXRD 8'h14
`define EPB_OFS_TXST 8'h18
`define EPB_OFS_TXND 8'h1C
`define EPB_OFS_HRD 8'h20
`define EPB_OFS_HWR 8'h24
`define EPB_OFS_DATA 8'h28
`define EPB_OFS_DSST 8'h2C
`define EPB_OFS_DSND 8'h30
`define EPB_OFS_DDST 8'h34
`define EPB_OFS_DSUM 8'h38
// Control register bits
`define EPB_CTRL_RECEIVE_ENABLE_BIT 0
`define EPB_CTRL_AINC 1
`define EPB_CTRL_DGO 2
`define EPB_CTRL_DCPY 3
// Status register bits
`define EPB_STAT_OVF 0
`define EPB_STAT_DBSY 1
`define EPB_STAT_FREE 16
// Reset values
`define EPB_CTRL_RST 4'h2
`define EPB_RXST_RST 13'h0000
`define EPB_RXND_RST 13'h0FFF
`define EPB_RXRD_RST 13'h0FFF
`define EPB_TXST_RST 13'h1000
`define EPB_TXND_RST 13'h1000
`endif

// >>> src/epb_pkg.sv
// Types shared by the packet buffer manager
`default_nettype none
package epb_pkg;
	// DMA engine states, Gray coded along the usual path
	typedef enum logic [1:0] {
		EPB_D_IDLE = 2'b00,
		EPB_D_RD = 2'b01,
		EPB_D_DAT = 2'b11,
		EPB_D_WR = 2'b10
	} epb_dma_st_t;
endpackage
`default_nettype wire

// >>> src/epb_mem.sv
// Packet memory: one write port, one registered read port, flip-flop storage
`timescale 1ns/10ps
`default_nettype none
module epb_mem
#(
	parameter int AW = 13,
	parameter int DW = 8
)
(
	input wire logic ref_clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic re,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem_r [2**AW];

	// Storage is not reset; contents are undefined until written
	always_ff @(posedge ref_clk)
	begin
		if (we)
			mem_r[waddr] <= wdata;
	end

	// One cycle read latency
	always_ff @(posedge ref_clk)
	begin
		if (re)
			rdata <= mem_r[raddr];
	end
endmodule // epb_mem
`default_nettype wire

// >>> src/epb_buf.sv
// Packet buffer manager: register slave, receive ring, host and DMA access
`timescale 1ns/10ps
`default_nettype none
`include "epb_defs.svh"
// ****************************************************************
// ****************************************************************
module epb_buf
	import epb_pkg::*;
#(
	parameter int AW = `EPB_AW
)
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_eop,
	input wire logic rx_bad,
	output logic [AW-1:0] tx_packet_start_ptr,
	output logic [AW-1:0] tx_packet_end_ptr,
	output logic rx_drop
);
	logic [3:0] ctrl_r;
	logic [AW-1:0] rx_region_start_ptr, rx_region_end_ptr;
	logic [AW-1:0] rx_hw_write_ptr, rx_host_release_ptr, rx_cur_r;
	logic [AW-1:0] host_buffer_read_ptr, host_buffer_write_ptr;
	logic [AW-1:0] dma_src_r, dma_end_r, dma_dst_r;
	logic [15:0] dma_sum_r;
	logic dma_hi_r, rx_drop_r, ovf_r, rd_ph_r, wait_r;
	epb_dma_st_t dma_st_r;
	logic [7:0] dma_byte_r, mem_q;
	logic receive_enable_bit, pointer_autoincrement_enable;
	logic is_data, hrd_issue, acc, rd_acc, wr_acc, hwr_mem;
	logic rx_go, rx_blk, rx_we, rx_commit, dma_we, dma_re, dma_step;
	logic [AW-1:0] rx_cur_inc, mem_waddr;
	logic [7:0] mem_wdata;
	logic mem_we;
	logic [AW:0] rx_free, ring_sz;
	logic [16:0] sum_add;
	logic [15:0] sum_nxt;
	logic [31:0] readdata_nxt;

	// Next address in the receive ring; only the end byte wraps
	function automatic logic [AW-1:0] rinc(input logic [AW-1:0] p);
		return (p == rx_region_end_ptr) ? rx_region_start_ptr : p + 1'b1;
	endfunction

	// Ring offset of an address; modular so a ring across 1FFF works
	function automatic logic [AW-1:0] roff(input logic [AW-1:0] p);
		return p - rx_region_start_ptr;
	endfunction

	// Byte-lane merge of a pointer register
	function automatic logic [AW-1:0] bmerge(input logic [AW-1:0] o);
		logic [15:0] v;
		v = 16'(o);
		if (byteenable[0])
			v[7:0] = writedata[7:0];
		if (byteenable[1])
			v[15:8] = writedata[15:8];
		return v[AW-1:0];
	endfunction

	// ************************************************
	// Bus decode and arbitration
	// ************************************************
	assign receive_enable_bit = ctrl_r[`EPB_CTRL_RECEIVE_ENABLE_BIT];
	assign pointer_autoincrement_enable = ctrl_r[`EPB_CTRL_AINC];
	assign is_data = ({address[7:2], 2'b00} == `EPB_OFS_DATA);
	// Host read owns the read port; DMA waits a cycle
	assign hrd_issue = read && is_data && wait_r && !rd_ph_r;
	// Data writes stall while the receiver holds the write port
	assign acc = wait_r && (read || write) &&
		(!is_data || (read ? rd_ph_r : !rx_we));
	assign rd_acc = acc && read;
	assign wr_acc = acc && write;
	assign hwr_mem = wr_acc && is_data;

	// ************************************************
	// Receive path
	// ************************************************
	assign rx_go = rx_valid && receive_enable_bit;
	// Blocked once dropping or on reaching the release pointer
	assign rx_blk = rx_drop_r || (rx_cur_r == rx_host_release_ptr);
	assign rx_we = rx_go && !rx_blk;
	assign rx_cur_inc = rinc(rx_cur_r);
	assign rx_commit = rx_go && rx_eop && !rx_bad && !rx_blk;

	// Write port: receiver first, then host, then DMA
	always_comb
	begin
		mem_we = rx_we || hwr_mem || dma_we;
		mem_waddr = dma_dst_r;
		mem_wdata = dma_byte_r;
		if (rx_we)
		begin
			mem_waddr = rx_cur_r;
			mem_wdata = rx_data;
		end
		else if (hwr_mem)
		begin
			mem_waddr = host_buffer_write_ptr;
			mem_wdata = writedata[7:0];
		end
	end

	// Free bytes between hardware write pointer and release pointer
	always_comb
	begin
		ring_sz = {1'b0, roff(rx_region_end_ptr)} + 1'b1;
		if (roff(rx_host_release_ptr) >= roff(rx_hw_write_ptr))
			rx_free = {1'b0, roff(rx_host_release_ptr) -
				roff(rx_hw_write_ptr)};
		else
			rx_free = ring_sz - {1'b0, roff(rx_hw_write_ptr)} +
				{1'b0, roff(rx_host_release_ptr)};
	end

	// Running and committed receive pointers; a bad or clipped
	// frame rewinds so the ring never holds a partial packet
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			rx_cur_r <= AW'(`EPB_RXST_RST);
			rx_hw_write_ptr <= AW'(`EPB_RXST_RST);
			rx_drop_r <= 1'b0;
		end
		else if (wr_acc && {address[7:2], 2'b00} == `EPB_OFS_RXST &&
			!receive_enable_bit)
		begin
			rx_cur_r <= bmerge(rx_region_start_ptr);
			rx_hw_write_ptr <= bmerge(rx_region_start_ptr);
			rx_drop_r <= 1'b0;
		end
		else if (!receive_enable_bit)
		begin
			rx_cur_r <= rx_hw_write_ptr;
			rx_drop_r <= 1'b0;
		end
		else if (rx_go && rx_eop)
		begin
			rx_drop_r <= 1'b0;
			if (rx_commit)
			begin
				rx_cur_r <= rx_cur_inc;
				rx_hw_write_ptr <= rx_cur_inc;
			end
			else
				rx_cur_r <= rx_hw_write_ptr;
		end
		else if (rx_go && rx_blk)
			rx_drop_r <= 1'b1;
		else if (rx_we)
			rx_cur_r <= rx_cur_inc;
	end

	// ************************************************
	// Register file
	// ************************************************
	// Ring bounds ignore writes while reception runs, so a stray
	// write cannot tear the ring under the receiver
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ctrl_r <= `EPB_CTRL_RST;
			rx_region_start_ptr <= AW'(`EPB_RXST_RST);
			rx_region_end_ptr <= AW'(`EPB_RXND_RST);
			rx_host_release_ptr <= AW'(`EPB_RXRD_RST);
			tx_packet_start_ptr <= AW'(`EPB_TXST_RST);
			tx_packet_end_ptr <= AW'(`EPB_TXND_RST);
		end
		else if (wr_acc)
		begin
			case ({address[7:2], 2'b00})
				`EPB_OFS_CTRL:
					if (byteenable[0])
						ctrl_r <= writedata[3:0] & 4'hB;
				`EPB_OFS_RXST:
					if (!receive_enable_bit)
						rx_region_start_ptr <= bmerge(rx_region_start_ptr);
				`EPB_OFS_RXND:
					if (!receive_enable_bit)
						rx_region_end_ptr <= bmerge(rx_region_end_ptr);
				`EPB_OFS_RXRD:
					rx_host_release_ptr <= bmerge(rx_host_release_ptr);
				// Used as written, no overlap check
				`EPB_OFS_TXST:
					tx_packet_start_ptr <= bmerge(tx_packet_start_ptr);
				`EPB_OFS_TXND:
					tx_packet_end_ptr <= bmerge(tx_packet_end_ptr);
				default:
					ctrl_r <= ctrl_r;
			endcase
		end
	end

	// Overflow flag: a new drop wins over a clear in the same cycle
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ovf_r <= 1'b0;
			rx_drop <= 1'b0;
		end
		else
		begin
			rx_drop <= rx_go && rx_blk;
			if (rx_go && rx_blk)
				ovf_r <= 1'b1;
			else if (wr_acc && {address[7:2], 2'b00} == `EPB_OFS_STAT &&
				byteenable[0] && writedata[`EPB_STAT_OVF])
				ovf_r <= 1'b0;
		end
	end

	// ************************************************
	// Host buffer pointers
	// ************************************************
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			host_buffer_read_ptr <= '0;
			host_buffer_write_ptr <= '0;
		end
		else if (wr_acc && {address[7:2], 2'b00} == `EPB_OFS_HRD)
			host_buffer_read_ptr <= bmerge(host_buffer_read_ptr);
		else if (wr_acc && {address[7:2], 2'b00} == `EPB_OFS_HWR)
			host_buffer_write_ptr <= bmerge(host_buffer_write_ptr);
		else if (acc && is_data && pointer_autoincrement_enable)
		begin
			if (read)
				host_buffer_read_ptr <= rinc(host_buffer_read_ptr);
			else
				host_buffer_write_ptr <= host_buffer_write_ptr + 1'b1;
		end
	end

	// ************************************************
	// DMA engine
	// ************************************************
	assign dma_re = (dma_st_r == EPB_D_RD) && !hrd_issue;
	assign dma_we = (dma_st_r == EPB_D_WR) && !rx_we && !hwr_mem;
	assign dma_step = ((dma_st_r == EPB_D_DAT) && !ctrl_r[`EPB_CTRL_DCPY]) ||
		dma_we;

	// Ones' complement sum over byte pairs, first byte high
	always_comb
	begin
		sum_add = {1'b0, dma_sum_r} +
			(dma_hi_r ? {1'b0, mem_q, 8'h00} : {9'h000, mem_q});
		sum_nxt = sum_add[15:0] + {15'h0000, sum_add[16]};
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			dma_st_r <= EPB_D_IDLE;
			dma_src_r <= '0;
			dma_end_r <= '0;
			dma_dst_r <= '0;
			dma_sum_r <= 16'h0000;
			dma_hi_r <= 1'b1;
			dma_byte_r <= 8'h00;
		end
		else
		begin
			case (dma_st_r)
				EPB_D_IDLE:
					if (wr_acc && {address[7:2], 2'b00} == `EPB_OFS_CTRL &&
						byteenable[0] && writedata[`EPB_CTRL_DGO])
					begin
						dma_sum_r <= 16'h0000;
						dma_hi_r <= 1'b1;
						dma_st_r <= EPB_D_RD;
					end
					else if (wr_acc && {address[7:2], 2'b00} == `EPB_OFS_DSST)
						dma_src_r <= bmerge(dma_src_r);
					else if (wr_acc && {address[7:2], 2'b00} == `EPB_OFS_DSND)
						dma_end_r <= bmerge(dma_end_r);
					else if (wr_acc && {address[7:2], 2'b00} == `EPB_OFS_DDST)
						dma_dst_r <= bmerge(dma_dst_r);
				EPB_D_RD:
					if (dma_re)
						dma_st_r <= EPB_D_DAT;
				EPB_D_DAT:
				begin
					dma_byte_r <= mem_q;
					dma_sum_r <= sum_nxt;
					dma_hi_r <= !dma_hi_r;
					if (ctrl_r[`EPB_CTRL_DCPY])
						dma_st_r <= EPB_D_WR;
				end
				EPB_D_WR:
					dma_st_r <= EPB_D_WR;
				default:
					dma_st_r <= EPB_D_IDLE;
			endcase
			// Reads wrap at the ring end, writes run linearly
			if (dma_step)
			begin
				if (dma_src_r == dma_end_r)
					dma_st_r <= EPB_D_IDLE;
				else
				begin
					dma_src_r <= rinc(dma_src_r);
					dma_dst_r <= dma_dst_r + 1'b1;
					dma_st_r <= EPB_D_RD;
				end
			end
		end
	end

	epb_mem #(
		.AW(AW),
		.DW(8)
	) u_mem (
		.ref_clk(ref_clk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.re(hrd_issue || dma_re),
		.raddr(hrd_issue ? host_buffer_read_ptr : dma_src_r),
		.rdata(mem_q)
	);

	// ************************************************
	// Bus response
	// ************************************************
	always_comb
	begin
		case ({address[7:2], 2'b00})
			`EPB_OFS_CTRL: readdata_nxt = 32'(ctrl_r);
			`EPB_OFS_STAT: readdata_nxt = 32'({rx_free, 14'h0000,
				dma_st_r != EPB_D_IDLE, ovf_r});
			`EPB_OFS_RXST: readdata_nxt = 32'(rx_region_start_ptr);
			`EPB_OFS_RXND: readdata_nxt = 32'(rx_region_end_ptr);
			`EPB_OFS_RXWR: readdata_nxt = 32'(rx_hw_write_ptr);
			`EPB_OFS_RXRD: readdata_nxt = 32'(rx_host_release_ptr);
			`EPB_OFS_TXST: readdata_nxt = 32'(tx_packet_start_ptr);
			`EPB_OFS_TXND: readdata_nxt = 32'(tx_packet_end_ptr);
			`EPB_OFS_HRD: readdata_nxt = 32'(host_buffer_read_ptr);
			`EPB_OFS_HWR: readdata_nxt = 32'(host_buffer_write_ptr);
			`EPB_OFS_DATA: readdata_nxt = 32'(mem_q);
			`EPB_OFS_DSST: readdata_nxt = 32'(dma_src_r);
			`EPB_OFS_DSND: readdata_nxt = 32'(dma_end_r);
			`EPB_OFS_DDST: readdata_nxt = 32'(dma_dst_r);
			`EPB_OFS_DSUM: readdata_nxt = 32'(~dma_sum_r);
			default: readdata_nxt = 32'h00000000;
		endcase
	end

	// Waitrequest drops for exactly one cycle per accepted request
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			wait_r <= 1'b1;
			rd_ph_r <= 1'b0;
			readdata <= 32'h00000000;
		end
		else
		begin
			wait_r <= !acc;
			rd_ph_r <= hrd_issue;
			if (rd_acc)
				readdata <= readdata_nxt;
		end
	end
	assign waitrequest = wait_r;

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	property p_rx_wrap;
		(rx_we && !rx_eop && rx_cur_r == rx_region_end_ptr) |=>
			(rx_cur_r == $past(rx_region_start_ptr));
	endproperty
	a_rx_wrap: assert property (p_rx_wrap)
		else $error("receive pointer did not wrap to start");

	property p_rx_range;
		rx_we |-> (roff(mem_waddr) <= roff(rx_region_end_ptr));
	endproperty
	a_rx_range: assert property (p_rx_range)
		else $error("receive write outside ring");

	property p_rx_release;
		rx_we |-> (mem_we && mem_waddr != rx_host_release_ptr &&
			mem_wdata == rx_data);
	endproperty
	a_rx_release: assert property (p_rx_release)
		else $error("receive wrote at release pointer");

	property p_rx_commit;
		rx_commit |=> (rx_hw_write_ptr == $past(rx_cur_inc));
	endproperty
	a_rx_commit: assert property (p_rx_commit)
		else $error("write pointer not advanced on good packet");

	property p_rx_full;
		(rx_go && rx_blk && !rx_eop) |=> (rx_drop_r && !rx_we) ##1 ovf_r;
	endproperty
	a_rx_full: assert property (p_rx_full)
		else $error("full ring did not drop data");

	property p_host_rd_wrap;
		(rd_acc && is_data && pointer_autoincrement_enable &&
			host_buffer_read_ptr == rx_region_end_ptr) |=>
			(host_buffer_read_ptr == $past(rx_region_start_ptr));
	endproperty
	a_host_rd_wrap: assert property (p_host_rd_wrap)
		else $error("host read pointer did not wrap");

	property p_host_wr_lin;
		(hwr_mem && pointer_autoincrement_enable) |=>
			(host_buffer_write_ptr == $past(host_buffer_write_ptr) + 1'b1);
	endproperty
	a_host_wr_lin: assert property (p_host_wr_lin)
		else $error("host write pointer not linear");

	property p_no_inc;
		(acc && is_data && !pointer_autoincrement_enable) |=>
			($stable(host_buffer_read_ptr) && $stable(host_buffer_write_ptr));
	endproperty
	a_no_inc: assert property (p_no_inc)
		else $error("pointer moved with autoincrement off");

	property p_dma_wrap;
		(dma_step && dma_src_r == rx_region_end_ptr &&
			dma_src_r != dma_end_r) |=>
			(dma_src_r == $past(rx_region_start_ptr) && dma_st_r == EPB_D_RD);
	endproperty
	a_dma_wrap: assert property (p_dma_wrap)
		else $error("DMA read pointer did not wrap");

	property p_host_wr_port;
		hwr_mem |-> (!rx_we && mem_waddr == host_buffer_write_ptr);
	endproperty
	a_host_wr_port: assert property (p_host_wr_port)
		else $error("host write collided with receive");
endmodule // epb_buf
`default_nettype wire

// >>> verification/epb_rx_src.sv
// Receive-side byte source standing in for the Ethernet receive path
`timescale 1ns/10ps
`default_nettype none
module epb_rx_src
(
	input wire logic ref_clk,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_eop,
	output logic rx_bad
);
	// ****************************************************************
	// Idle levels and byte sender
	// ****************************************************************
	// Between strobes the data line shows the inverse of the last byte,
	// so a design that samples it without the strobe stores garbage
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'hFF;
		rx_eop = 1'b0;
		rx_bad = 1'b0;
	end
	// Release the strobe lines after a byte
	task automatic idle(input logic [7:0] last);
		rx_valid <= 1'b0;
		rx_eop <= 1'b0;
		rx_bad <= 1'b0;
		rx_data <= ~last;
	endtask
	// Send n bytes, first in b[7:0]; gap idle cycles after each (0 = burst)
	task automatic send(input logic [31:0] b, input int n, input logic bad,
		input int gap);
		int i;
		for (i = 0; i < n; i++)
		begin
			@(posedge ref_clk);
			rx_valid <= 1'b1;
			rx_data <= b[8*i +: 8];
			rx_eop <= (i == n - 1);
			rx_bad <= bad && (i == n - 1);
			if (gap > 0)
			begin
				@(posedge ref_clk);
				idle(b[8*i +: 8]);
				repeat (gap - 1) @(posedge ref_clk);
			end
		end
		@(posedge ref_clk);
		idle(b[8*(n-1) +: 8]);
	endtask
endmodule // epb_rx_src
`default_nettype wire

// >>> verification/ethernet_packet_buffer_manager_tb.sv
// Self-checking bench for the packet buffer manager
`timescale 1ns/10ps
`default_nettype none
`include "epb_defs.svh"
module ethernet_packet_buffer_manager_tb;
	// ****************************************************************
	// Signals, clock and instances
	// ****************************************************************
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] e;
		logic [31:0] m;
	} epb_row_t;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hF;
	logic [31:0] readdata;
	logic waitrequest;
	logic rx_valid, rx_eop, rx_bad, rx_drop;
	logic [7:0] rx_data;
	logic [12:0] tx_packet_start_ptr, tx_packet_end_ptr;
	logic [31:0] q;
	int n_errors = 0;
	int checks_done = 0;
	int n_drop = 0;
	// Reset values of every register except DATA, DSST, DSND and DDST, plus one unmapped offset
	epb_row_t rows [12] = '{
		{`EPB_OFS_CTRL, 32'h2, 32'hF}, {`EPB_OFS_STAT, 32'h0FFF0000, 32'h3FFF0003},
		{`EPB_OFS_RXST, 32'h0, 32'h1FFF}, {`EPB_OFS_RXND, 32'hFFF, 32'h1FFF},
		{`EPB_OFS_RXWR, 32'h0, 32'h1FFF}, {`EPB_OFS_RXRD, 32'hFFF, 32'h1FFF},
		{`EPB_OFS_TXST, 32'h1000, 32'h1FFF}, {`EPB_OFS_TXND, 32'h1000, 32'h1FFF},
		{`EPB_OFS_HRD, 32'h0, 32'h1FFF}, {`EPB_OFS_HWR, 32'h0, 32'h1FFF},
		{`EPB_OFS_DSUM, 32'hFFFF, 32'hFFFF}, {8'h3C, 32'h0, 32'hFFFFFFFF}};
	// 250 MHz clock
	initial
	begin
		forever #2 ref_clk = ~ref_clk;
	end
	// Count discard pulses; each one stands for a single cycle
	always @(posedge ref_clk)
	begin
		if (rx_drop === 1'b1)
			n_drop <= n_drop + 1;
	end
	epb_buf i_dut (.ref_clk(ref_clk), .reset(reset), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_eop(rx_eop), .rx_bad(rx_bad),
		.tx_packet_start_ptr(tx_packet_start_ptr),
		.tx_packet_end_ptr(tx_packet_end_ptr), .rx_drop(rx_drop));
	epb_rx_src i_src (.ref_clk(ref_clk), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_eop(rx_eop), .rx_bad(rx_bad));
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One Avalon cycle; request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		i = 0;
		@(posedge ref_clk);
		read <= ~w;
		write <= w;
		address <= a;
		writedata <= d;
		@(posedge ref_clk);
		while (waitrequest !== 1'b0)
		begin
			i++;
			if (i > 500)
			begin
				n_errors++;
				$display("Error bus timeout at %h", a);
				test_done;
			end
			@(posedge ref_clk);
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a,
		input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
		bus(1'b0, a, 32'h0);
		chk(nm, q & m, e);
	endtask
	// Read one memory byte through the host read pointer
	task automatic memchk(input logic [12:0] a, input logic [7:0] e);
		wr(`EPB_OFS_HRD, {19'h0, a});
		rdchk("mem", `EPB_OFS_DATA, {24'h0, e}, 32'hFF);
	endtask
	// Poll the busy flag with a bound; a hung engine ends the run
	task automatic dma_wait;
		int i;
		for (i = 0; i < 100; i++)
		begin
			bus(1'b0, `EPB_OFS_STAT, 32'h0);
			if (q[`EPB_STAT_DBSY] === 1'b0)
				return;
		end
		n_errors++;
		$display("Error dma timeout");
		test_done;
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		int k;
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		for (k = 0; k < 12; k++)
			rdchk("reg", rows[k].a, rows[k].e, rows[k].m);
		$display("test reset values done");
		// Host writes run straight across the top of memory
		wr(`EPB_OFS_HWR, 32'h1FFF);
		wr(`EPB_OFS_DATA, 32'hA5);
		wr(`EPB_OFS_DATA, 32'h5A);
		rdchk("hwr", `EPB_OFS_HWR, 32'h0001, 32'h1FFF);
		wr(`EPB_OFS_DATA, 32'hEE);
		wr(`EPB_OFS_DATA, 32'h77);
		wr(`EPB_OFS_HRD, 32'h1FFF);
		rdchk("rd0", `EPB_OFS_DATA, 32'hA5, 32'hFF);
		rdchk("rd1", `EPB_OFS_DATA, 32'h5A, 32'hFF);
		rdchk("hrd", `EPB_OFS_HRD, 32'h0001, 32'h1FFF);
		// Autoincrement off: both pointers must hold still
		wr(`EPB_OFS_CTRL, 32'h0);
		wr(`EPB_OFS_DATA, 32'h33);
		rdchk("hwr", `EPB_OFS_HWR, 32'h0003, 32'h1FFF);
		wr(`EPB_OFS_HRD, 32'h0003);
		rdchk("rd2", `EPB_OFS_DATA, 32'h33, 32'hFF);
		rdchk("rd3", `EPB_OFS_DATA, 32'h33, 32'hFF);
		rdchk("hrd", `EPB_OFS_HRD, 32'h0003, 32'h1FFF);
		$display("test host access done");
		// Four-byte ring across the top boundary, set while disabled
		wr(`EPB_OFS_CTRL, 32'h2);
		wr(`EPB_OFS_RXST, 32'h1FFE);
		wr(`EPB_OFS_RXND, 32'h0001);
		wr(`EPB_OFS_RXRD, 32'h0001);
		wr(`EPB_OFS_CTRL, 32'h3);
		rdchk("rxwr", `EPB_OFS_RXWR, 32'h1FFE, 32'h1FFF);
		wr(`EPB_OFS_RXST, 32'h0100);
		rdchk("rxst", `EPB_OFS_RXST, 32'h1FFE, 32'h1FFF);
		i_src.send(32'h00998877, 2, 1'b1, 0);
		rdchk("rxwr", `EPB_OFS_RXWR, 32'h1FFE, 32'h1FFF);
		i_src.send(32'h00332211, 3, 1'b0, 2);
		rdchk("rxwr", `EPB_OFS_RXWR, 32'h0001, 32'h1FFF);
		rdchk("free", `EPB_OFS_STAT, 32'h0, 32'h3FFF0000);
		// Ring is full: both bytes of the next frame are thrown away
		i_src.send(32'h6655, 2, 1'b0, 0);
		rdchk("rxwr", `EPB_OFS_RXWR, 32'h0001, 32'h1FFF);
		rdchk("ovf", `EPB_OFS_STAT, 32'h1, 32'h1);
		chk("drops", n_drop, 32'h2);
		// Overflow flag is sticky until software writes one to clear it
		wr(`EPB_OFS_STAT, 32'h1);
		rdchk("ovfclr", `EPB_OFS_STAT, 32'h0, 32'h1);
		memchk(13'h0001, 8'hEE);
		memchk(13'h0002, 8'h77);
		// Host frees space, reception resumes and wraps end to start
		wr(`EPB_OFS_RXRD, 32'h1FFF);
		i_src.send(32'h44, 1, 1'b0, 0);
		rdchk("rxwr", `EPB_OFS_RXWR, 32'h1FFE, 32'h1FFF);
		wr(`EPB_OFS_HRD, 32'h0001);
		rdchk("rd4", `EPB_OFS_DATA, 32'h44, 32'hFF);
		rdchk("rd5", `EPB_OFS_DATA, 32'h11, 32'hFF);
		memchk(13'h1FFF, 8'h22);
		$display("test receive ring done");
		// DMA copy reads across the ring end, writes linearly
		wr(`EPB_OFS_DSST, 32'h0001);
		wr(`EPB_OFS_DSND, 32'h1FFF);
		wr(`EPB_OFS_DDST, 32'h0200);
		wr(`EPB_OFS_CTRL, 32'hF);
		dma_wait;
		memchk(13'h0200, 8'h44);
		memchk(13'h0201, 8'h11);
		memchk(13'h0202, 8'h22);
		// Checksum of bytes 11 22 inverts the pair sum 1122
		wr(`EPB_OFS_DSST, 32'h1FFE);
		wr(`EPB_OFS_CTRL, 32'h7);
		dma_wait;
		rdchk("dsum", `EPB_OFS_DSUM, 32'hEEDD, 32'hFFFF);
		$display("test dma done");
		// Transmit pointers overlapping the ring are used as written
		wr(`EPB_OFS_TXST, 32'h1FFE);
		wr(`EPB_OFS_TXND, 32'h0001);
		chk("txst", {19'h0, tx_packet_start_ptr}, 32'h1FFE);
		chk("txnd", {19'h0, tx_packet_end_ptr}, 32'h0001);
		$display("test transmit pointers done");
		// Second reset in mid-run restores the defaults of waitrequest, TXST, CTRL, RXST and RXWR
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk("wait", {31'h0, waitrequest}, 32'h1);
		chk("txst", {19'h0, tx_packet_start_ptr}, 32'h1000);
		reset <= 1'b0;
		rdchk("ctrl", `EPB_OFS_CTRL, 32'h2, 32'hF);
		rdchk("rxst", `EPB_OFS_RXST, 32'h0, 32'h1FFF);
		rdchk("rxwr", `EPB_OFS_RXWR, 32'h0, 32'h1FFF);
		$display("test mid-run reset done");
		test_done;
	end
endmodule // ethernet_packet_buffer_manager_tb
`default_nettype wire
